// File: rtl/element_decode.sv
`timescale 1ns/100ps
`include "map_defines.svh"

module element_decode
    import map_pkg::*;
(
    input wire logic [31:0] word,
    output element_s elem,
    output logic is_region,
    output logic grant,
    output logic is_null,
    output logic is_ack,
    output logic is_reserved,
    output logic is_expand
);
    assign elem = element_s'(word);
    // Request, request/data, both maintenance kinds and both grants
    assign is_region = (elem.code >= `UC_REQUEST) && (elem.code <= `UC_LONG_GRANT);
    assign grant = (elem.code == `UC_SHORT_GRANT) || (elem.code == `UC_LONG_GRANT);
    assign is_null = (elem.code == `UC_NULL);
    assign is_ack = (elem.code == `UC_DATA_ACK);
    assign is_reserved = (elem.code == `UC_ZERO)
        || ((elem.code >= `UC_RSV_LO) && (elem.code <= `UC_RSV_HI));
    assign is_expand = (elem.code == `UC_EXPAND);
endmodule : element_decode

// File: rtl/map_defines.svh
`ifndef MAP_DEFINES_SVH
`define MAP_DEFINES_SVH

// ----------------------------------------------------------------
// Element and header layout
// ----------------------------------------------------------------
`define SID_W 14
`define CODE_W 4
`define OFF_W 14
`define BO_W 4
`define M_W 5
`define TIME_FULL 6'h1A
`define OFF_ZERO 14'h0000
`define OFF_ONE 14'h0001
`define RSVD_FILL 8'h00
`define BO_EXP_MASK 32'h0F0F_0F0F
`define CFG_MASK 32'h00FF_FF1F
`define WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// Interval usage codes
// ----------------------------------------------------------------
`define UC_ZERO 4'h0
`define UC_REQUEST 4'h1
`define UC_REQ_DATA 4'h2
`define UC_INIT_MAINT 4'h3
`define UC_STA_MAINT 4'h4
`define UC_SHORT_GRANT 4'h5
`define UC_LONG_GRANT 4'h6
`define UC_NULL 4'h7
`define UC_DATA_ACK 4'h8
`define UC_RSV_LO 4'h9
`define UC_RSV_HI 4'hE
`define UC_EXPAND 4'hF

// ----------------------------------------------------------------
// Channel descriptor type/length/value codes
// ----------------------------------------------------------------
`define TLV_SYMBOL_RATE 8'h01
`define TLV_FREQ 8'h02
`define TLV_PREAMBLE 8'h03
`define TLV_BURST 8'h04
`define TLV_SR_LEN 8'h01
`define TLV_FREQ_LEN 8'h04
`define TLV_PRE_MIN 8'h01
`define TLV_PRE_MAX 8'h80
`define TLV_LEN_ZERO 8'h00

// ----------------------------------------------------------------
// Headend register offsets and bits
// ----------------------------------------------------------------
`define HE_CTRL 12'h000
`define HE_HDR 12'h004
`define HE_ALLOC 12'h008
`define HE_ACK 12'h00C
`define HE_BO 12'h010
`define HE_IDX 12'h014
`define HE_ELEM 12'h018
`define HE_STATUS 12'h01C
`define CTRL_START 0
`define CTRL_BUSY 1

// ----------------------------------------------------------------
// Modem register offsets and status bits
// ----------------------------------------------------------------
`define MD_STATUS 12'h000
`define MD_CONFIG 12'h004
`define MD_HDR 12'h008
`define MD_ALLOC 12'h00C
`define MD_ACK 12'h010
`define MD_BO 12'h014
`define MD_IDX 12'h018
`define MD_ELEM 12'h01C
`define MD_COUNTS 12'h020
`define MD_TXTIME 12'h024
`define MD_TLV 12'h028
`define ST_W 8
`define ST_DONE 0
`define ST_CHAN 1
`define ST_UCD 2
`define ST_BO 3
`define ST_FIRST 4
`define ST_POST 5
`define ST_OVF 6
`define ST_ACKED 7

`endif

// File: rtl/map_headend.sv
`timescale 1ns/100ps
`include "map_defines.svh"

module map_headend
    import map_pkg::*;
#(
    parameter int DEPTH = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    map_link_if.headend link
);
    localparam int IW = $clog2(DEPTH);

    typedef enum logic [2:0] {S_IDLE, S_HDR0, S_ALLOC, S_ACK, S_BO, S_ELEM} hstate_e;

    typedef struct packed {
        hstate_e st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        hdr0_s hdr;
        logic [31:0] alloc;
        logic [31:0] ack;
        logic [31:0] bo;
        logic [IW-1:0] wr_idx;
        logic [IW-1:0] rd_idx;
        logic [DEPTH-1:0][31:0] mem;
        logic [7:0] sent;
        logic [`OFF_W-1:0] ext_left;
        logic after_null;
        logic [`OFF_W-1:0] map_len;
        logic [15:0] maps_sent;
        logic [31:0] ldata;
        logic lvalid;
        logic llast;
    } hregs_s;

    hregs_s q;
    hregs_s d;
    element_s el;
    logic el_null;
    logic el_expand;

    element_decode u_dec (
        .word(q.mem[q.rd_idx]),
        .elem(el),
        .is_region(),
        .grant(),
        .is_null(el_null),
        .is_ack(),
        .is_reserved(),
        .is_expand(el_expand)
    );

    // ----------------------------------------------------------------
    // Register access and map emission
    // ----------------------------------------------------------------
    always_comb begin
        logic acc;
        logic hit;
        logic [31:0] rd;
        logic take;
        logic load;
        element_s e;
        d = q;
        acc = psel & penable;
        take = q.lvalid & link.ready;
        hit = 1'b1;
        rd = `WORD_ZERO;
        load = 1'b0;
        e = el;
        case (paddr)
            `HE_CTRL: rd[`CTRL_BUSY] = (q.st != S_IDLE);
            `HE_HDR: rd = q.hdr;
            `HE_ALLOC: rd = q.alloc;
            `HE_ACK: rd = q.ack;
            `HE_BO: rd = q.bo;
            `HE_IDX: rd = 32'(q.wr_idx);
            `HE_ELEM: rd = q.mem[q.wr_idx];
            `HE_STATUS: rd = 32'(q.maps_sent);
            default: hit = 1'b0;
        endcase
        if (acc && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = rd;
            d.pslverr = !hit;
        end else if (q.pready) begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
        end
        if (acc && q.pready && pwrite && hit) begin
            case (paddr)
                `HE_CTRL: begin
                    if (pwdata[`CTRL_START] && (q.st == S_IDLE)) begin
                        d.st = S_HDR0;
                        d.ldata = q.hdr;
                        d.lvalid = 1'b1;
                        d.llast = 1'b0;
                        d.rd_idx = '0;
                        d.sent = 8'h00;
                        d.ext_left = `OFF_ZERO;
                        d.after_null = 1'b0;
                    end
                end
                `HE_HDR: begin
                    d.hdr = pwdata;
                    d.hdr.rsvd = `RSVD_FILL;
                end
                `HE_ALLOC: d.alloc = pwdata;
                `HE_ACK: d.ack = pwdata;
                `HE_BO: d.bo = pwdata & `BO_EXP_MASK;
                `HE_IDX: d.wr_idx = pwdata[IW-1:0];
                `HE_ELEM: begin
                    d.mem[q.wr_idx] = pwdata;
                    d.wr_idx = q.wr_idx + 1'b1;
                end
                default: ;
            endcase
        end
        if (take) begin
            unique case (q.st)
                S_HDR0: begin
                    d.st = S_ALLOC;
                    d.ldata = q.alloc;
                end
                S_ALLOC: begin
                    d.st = S_ACK;
                    d.ldata = q.ack;
                end
                S_ACK: begin
                    d.st = S_BO;
                    d.ldata = q.bo;
                    d.llast = (q.hdr.n_elem == 8'h00);
                end
                S_BO: ;
                S_ELEM: ;
                S_IDLE: ;
            endcase
            if (q.llast) begin
                d.st = S_IDLE;
                d.lvalid = 1'b0;
                d.llast = 1'b0;
                d.maps_sent = q.maps_sent + 16'h0001;
            end
        end
        load = take && !q.llast && ((q.st == S_BO) || (q.st == S_ELEM));
        if (load) begin
            d.st = S_ELEM;
            d.rd_idx = q.rd_idx + 1'b1;
            if (q.ext_left != `OFF_ZERO) begin
                // Extension words pass untouched
                d.ldata = q.mem[q.rd_idx];
                d.ext_left = q.ext_left - `OFF_ONE;
                d.llast = (q.ext_left == `OFF_ONE) && (q.sent == q.hdr.n_elem);
            end else begin
                if (q.sent == 8'h00) begin
                    e.offset = `OFF_ZERO;
                end else if (q.after_null) begin
                    e.offset = q.map_len;
                end
                if (el_null) begin
                    e.service_flow_id = '0;
                    d.after_null = 1'b1;
                    d.map_len = el.offset;
                end
                if (el_expand) begin
                    d.ext_left = el.offset;
                end
                d.sent = q.sent + 8'h01;
                d.llast = (!el_expand || (el.offset == `OFF_ZERO))
                    && ((q.sent + 8'h01) == q.hdr.n_elem);
                d.ldata = e;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign link.data = q.ldata;
    assign link.valid = q.lvalid;
    assign link.last = q.llast;
endmodule : map_headend

// File: rtl/map_link_if.sv
`timescale 1ns/100ps

interface map_link_if;
    logic [31:0] data;
    logic valid;
    logic ready;
    logic last;

    modport headend (output data, output valid, output last, input ready);
    modport modem (input data, input valid, input last, output ready);
endinterface : map_link_if

// File: rtl/map_modem.sv
`timescale 1ns/100ps
`include "map_defines.svh"

module map_modem
    import map_pkg::*;
#(
    parameter int DEPTH = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    map_link_if.modem link
);
    localparam int IW = $clog2(DEPTH);
    localparam logic [IW:0] DEPTH_C = (IW+1)'(DEPTH);

    typedef enum logic [2:0] {S_HDR0, S_ALLOC, S_ACK, S_BO, S_ELEM, S_SKIP} mstate_e;

    typedef struct packed {
        mstate_e st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic ready;
        modem_cfg_s cfg;
        logic [`ST_W-1:0] sts;
        hdr0_s hdr;
        logic [31:0] alloc;
        logic [31:0] ack;
        logic [31:0] bo;
        logic [31:0] txtime;
        logic [15:0] type_length_value;
        logic [IW-1:0] idx;
        logic [IW:0] wr;
        logic [DEPTH-1:0][31:0] mem;
        logic [7:0] elems;
        logic [`OFF_W-1:0] ext_left;
        logic after_null;
        logic [`OFF_W-1:0] map_len;
        logic prev_grant;
        logic [`OFF_W-1:0] prev_off;
        logic [7:0] n_int;
        logic [7:0] n_ack;
        logic [7:0] n_pend;
        logic [7:0] n_rsv;
    } mregs_s;

    mregs_s q;
    mregs_s d;
    element_s el;
    logic el_region;
    logic el_grant;
    logic el_null;
    logic el_ack;
    logic el_rsv;
    logic el_expand;

    element_decode u_dec (
        .word(link.data),
        .elem(el),
        .is_region(el_region),
        .grant(el_grant),
        .is_null(el_null),
        .is_ack(el_ack),
        .is_reserved(el_rsv),
        .is_expand(el_expand)
    );

    // ----------------------------------------------------------------
    // Register access and map parsing
    // ----------------------------------------------------------------
    always_comb begin
        logic acc;
        logic hit;
        logic [31:0] rd;
        logic take;
        logic store;
        logic [`ST_W-1:0] ev;
        logic [`ST_W-1:0] clr;
        logic [31:0] t;
        d = q;
        acc = psel & penable;
        take = link.valid & q.ready;
        store = 1'b0;
        hit = 1'b1;
        rd = `WORD_ZERO;
        ev = '0;
        clr = '0;
        t = eff_time(link.data, q.cfg.m);
        d.ready = 1'b1;
        case (paddr)
            `MD_STATUS: rd = 32'(q.sts);
            `MD_CONFIG: rd = q.cfg;
            `MD_HDR: rd = q.hdr;
            `MD_ALLOC: rd = q.alloc;
            `MD_ACK: rd = q.ack;
            `MD_BO: rd = q.bo;
            `MD_IDX: rd = 32'(q.idx);
            `MD_ELEM: rd = q.mem[q.idx];
            `MD_COUNTS: rd = {q.n_rsv, q.n_pend, q.n_ack, q.n_int};
            `MD_TXTIME: rd = q.txtime;
            `MD_TLV: rd = {15'h0000, tlv_len_ok(q.type_length_value[15:8], q.type_length_value[7:0]), q.type_length_value};
            default: hit = 1'b0;
        endcase
        if (acc && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = rd;
            d.pslverr = !hit;
        end else if (q.pready) begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
        end
        if (acc && q.pready && pwrite && hit) begin
            case (paddr)
                `MD_STATUS: clr = pwdata[`ST_W-1:0];
                `MD_CONFIG: d.cfg = pwdata & `CFG_MASK;
                `MD_IDX: d.idx = pwdata[IW-1:0];
                `MD_TXTIME: d.txtime = pwdata;
                `MD_TLV: d.type_length_value = pwdata[15:0];
                default: ;
            endcase
        end
        if (take) begin
            unique case (q.st)
                S_HDR0: begin
                    // Reserved byte kept as received, never interpreted
                    d.hdr = link.data;
                    d.elems = 8'h00;
                    d.wr = '0;
                    d.ext_left = `OFF_ZERO;
                    d.after_null = 1'b0;
                    d.prev_grant = 1'b0;
                    d.n_int = 8'h00;
                    d.n_ack = 8'h00;
                    d.n_pend = 8'h00;
                    d.n_rsv = 8'h00;
                    if (link.data[31:24] != q.cfg.chan) begin
                        ev[`ST_CHAN] = 1'b1;
                        d.st = S_SKIP;
                    end else begin
                        d.st = S_ALLOC;
                    end
                    if (link.data[23:16] != q.cfg.upstream_channel_descriptor) begin
                        ev[`ST_UCD] = 1'b1;
                    end
                end
                S_ALLOC: begin
                    d.alloc = t;
                    d.st = S_ACK;
                end
                S_ACK: begin
                    d.ack = t;
                    if (t >= q.txtime) begin
                        ev[`ST_ACKED] = 1'b1;
                    end
                    d.st = S_BO;
                end
                S_BO: begin
                    d.bo = link.data;
                    if ((link.data & ~`BO_EXP_MASK) != `WORD_ZERO) begin
                        ev[`ST_BO] = 1'b1;
                    end
                    d.st = (q.hdr.n_elem == 8'h00) ? S_SKIP : S_ELEM;
                end
                S_ELEM: begin
                    if (q.ext_left != `OFF_ZERO) begin
                        d.ext_left = q.ext_left - `OFF_ONE;
                        store = 1'b1;
                    end else if (q.elems != q.hdr.n_elem) begin
                        store = 1'b1;
                        d.elems = q.elems + 8'h01;
                        if ((q.elems == 8'h00) && (el.offset != `OFF_ZERO)) begin
                            ev[`ST_FIRST] = 1'b1;
                        end
                        if (el_expand) begin
                            d.ext_left = el.offset;
                        end else if (el_rsv) begin
                            d.n_rsv = q.n_rsv + 8'h01;
                        end else if (q.after_null) begin
                            if (el.offset != q.map_len) begin
                                ev[`ST_POST] = 1'b1;
                            end
                            if (el_ack) begin
                                d.n_ack = q.n_ack + 8'h01;
                            end
                            if (el_grant) begin
                                d.n_pend = q.n_pend + 8'h01;
                            end
                        end else if (el_null || el_region) begin
                            if (q.prev_grant && (el.offset == q.prev_off)) begin
                                d.n_pend = q.n_pend + 8'h01;
                            end
                            d.prev_grant = el_grant;
                            d.prev_off = el.offset;
                            if (el_null) begin
                                d.after_null = 1'b1;
                                d.map_len = el.offset;
                            end else begin
                                d.n_int = q.n_int + 8'h01;
                            end
                        end
                    end
                end
                S_SKIP: ;
            endcase
            if (store) begin
                if (q.wr != DEPTH_C) begin
                    d.mem[q.wr[IW-1:0]] = link.data;
                    d.wr = q.wr + 1'b1;
                end else begin
                    ev[`ST_OVF] = 1'b1;
                end
            end
            if (link.last) begin
                d.st = S_HDR0;
                if ((q.st != S_HDR0) && (q.hdr.chan == q.cfg.chan)) begin
                    ev[`ST_DONE] = 1'b1;
                end
            end
        end
        // New events win over a clear in the same cycle
        d.sts = (q.sts & ~clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign link.ready = q.ready;
endmodule : map_modem

// File: rtl/map_pkg.sv
`include "map_defines.svh"

package map_pkg;

    typedef struct packed {
        logic [`SID_W-1:0] service_flow_id;
        logic [`CODE_W-1:0] code;
        logic [`OFF_W-1:0] offset;
    } element_s;

    typedef struct packed {
        logic [7:0] chan;
        logic [7:0] ucd_cnt;
        logic [7:0] n_elem;
        logic [7:0] rsvd;
    } hdr0_s;

    typedef struct packed {
        logic [`BO_W-1:0] unused;
        logic [`BO_W-1:0] exp;
    } bo_byte_s;

    typedef struct packed {
        bo_byte_s rng_start;
        bo_byte_s rng_end;
        bo_byte_s data_start;
        bo_byte_s data_end;
    } backoff_s;

    typedef struct packed {
        logic [7:0] unused;
        logic [7:0] chan;
        logic [7:0] upstream_channel_descriptor;
        logic [2:0] pad;
        logic [`M_W-1:0] m;
    } modem_cfg_s;

    function automatic logic [31:0] eff_time(input logic [31:0] t, input logic [`M_W-1:0] m);
        logic [5:0] keep;
        keep = `TIME_FULL - {1'b0, m};
        return t & ((32'h0000_0001 << keep) - 32'h0000_0001);
    endfunction : eff_time

    function automatic logic tlv_len_ok(input logic [7:0] ty, input logic [7:0] len);
        logic ok;
        ok = 1'b0;
        case (ty)
            `TLV_SYMBOL_RATE: ok = (len == `TLV_SR_LEN);
            `TLV_FREQ: ok = (len == `TLV_FREQ_LEN);
            `TLV_PREAMBLE: ok = (len >= `TLV_PRE_MIN) && (len <= `TLV_PRE_MAX);
            `TLV_BURST: ok = (len != `TLV_LEN_ZERO);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : tlv_len_ok

endpackage : map_pkg

// File: test/map_link_properties.sv
`timescale 1ns/100ps
module map_link_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] data,
    input wire logic valid,
    input wire logic ready,
    input wire logic last
);
    // ----
    // Word tracking
    // ----
    logic [7:0] widx_q;
    logic [7:0] n_q;
    logic null_q;
    logic [13:0] off_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            widx_q <= 8'h00;
            n_q <= 8'h00;
            null_q <= 1'b0;
            off_q <= 14'h0000;
        end else if (valid && ready) begin
            widx_q <= last ? 8'h00 : widx_q + 8'h01;
            if (widx_q == 8'h00) n_q <= data[15:8];
            if (widx_q >= 8'h04 && data[17:14] == 4'h7) off_q <= data[13:0];
            null_q <= !last && (null_q || (widx_q >= 8'h04 && data[17:14] == 4'h7));
        end
    end
    property p_rsvd; valid && widx_q == 8'h00 |-> data[7:0] == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved byte set");
    property p_bo_rng; valid && widx_q == 8'h03 |-> data[31:28] == 0 && data[23:20] == 0;
    endproperty
    a_bo_rng: assert property (p_bo_rng) else $error("ranging upper bits");
    property p_bo_dat; valid && widx_q == 8'h03 |-> data[15:12] == 0 && data[7:4] == 0;
    endproperty
    a_bo_dat: assert property (p_bo_dat) else $error("data upper bits");
    property p_first; valid && widx_q == 8'h04 |-> data[13:0] == 14'h0000; endproperty
    a_first: assert property (p_first) else $error("first offset");
    property p_null; valid && widx_q >= 8'h04 && data[17:14] == 4'h7 |-> data[31:18] == 0;
    endproperty
    a_null: assert property (p_null) else $error("terminator flow");
    property p_trail; valid && null_q |-> data[13:0] == off_q; endproperty
    a_trail: assert property (p_trail) else $error("trailer offset");
    property p_count; valid && last |-> widx_q == n_q + 8'h03; endproperty
    a_count: assert property (p_count) else $error("element count");
    property p_drop; valid && ready && last |=> !valid; endproperty
    a_drop: assert property (p_drop) else $error("valid after last");
    property p_burst; valid && ready && !last |=> valid; endproperty
    a_burst: assert property (p_burst) else $error("gap in map");
endmodule : map_link_properties

// File: test/tb.sv
`timescale 1ns/100ps
`include "map_defines.svh"
module tb
    import map_pkg::*;
;
    logic pclk, presetn, h_psel, m_psel, penable, pwrite, h_pready, m_pready, h_err, m_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, h_prdata, m_prdata, rdata;
    logic err;
    int n_errors = 0;
    int total_checks = 0;
    map_link_if map_link_if_inst ();
    map_headend #(.DEPTH(16)) map_headend_inst (.pclk(pclk), .presetn(presetn), .psel(h_psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(h_prdata),
        .pready(h_pready), .pslverr(h_err), .link(map_link_if_inst.headend));
    map_modem #(.DEPTH(16)) map_modem_inst (.pclk(pclk), .presetn(presetn), .psel(m_psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(m_prdata),
        .pready(m_pready), .pslverr(m_err), .link(map_link_if_inst.modem));
    map_link_properties map_link_properties_inst (.pclk(pclk), .presetn(presetn),
        .data(map_link_if_inst.data), .valid(map_link_if_inst.valid),
        .ready(map_link_if_inst.ready), .last(map_link_if_inst.last));
    // ----
    // Shared tasks
    // ----
    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic he, input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        h_psel <= he;
        m_psel <= !he;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while ((he ? h_pready : m_pready) !== 1'b1 && n < 20);
        rdata = he ? h_prdata : m_prdata;
        err = he ? h_err : m_err;
        if (n >= 20) begin
            n_errors++;
            complete_run();
        end
        h_psel <= 1'b0;
        m_psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic send_map();
        int k;
        apb(1'b1, 1'b1, `HE_CTRL, 32'h0000_0001);
        for (k = 0; k < 50; k++) begin
            apb(1'b1, 1'b0, `HE_CTRL, 32'h0000_0000);
            if (rdata[`CTRL_BUSY] === 1'b0) break;
        end
        if (k == 50) begin
            n_errors++;
            complete_run();
        end
    endtask : send_map
    // ----
    // Scenarios
    // ----
    task automatic t_decode();
        logic [3:0] uc [13];
        logic [13:0] off [13];
        uc = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h9, 4'hE, 4'hF, 4'h7, 4'h8, 4'h5};
        off = '{14'h0000, 14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h0008, 14'h0009,
            14'h0009, 14'h0009, 14'h0000, 14'h000A, 14'h000A, 14'h000A};
        apb(1'b1, 1'b1, `HE_HDR, 32'h0503_0D00);
        apb(1'b1, 1'b1, `HE_IDX, 32'h0000_0000);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, 1'b1, `HE_ELEM, {14'h0155, uc[i], off[i]});
        end
        send_map();
        apb(1'b0, 1'b0, `MD_COUNTS, 32'h0000_0000);
        check(rdata, 32'h0302_0106);
        apb(1'b0, 1'b1, `MD_IDX, 32'h0000_000A);
        apb(1'b0, 1'b0, `MD_ELEM, 32'h0000_0000);
        check(rdata, {14'h0000, `UC_NULL, 14'h000A});
        apb(1'b1, 1'b0, `HE_STATUS, 32'h0000_0000);
        check(rdata, 32'h0000_0002);
    endtask : t_decode
    task automatic t_map();
        logic [31:0] wr [4];
        logic [31:0] ex [4];
        wr = '{{14'h0123, 4'h5, 14'h0009}, {14'h0055, 4'h1, 14'h0020},
            {14'h3FFF, 4'h7, 14'h0030}, {14'h0044, 4'h8, 14'h0007}};
        ex = '{{14'h0123, 4'h5, 14'h0000}, wr[1], {14'h0000, 4'h7, 14'h0030},
            {14'h0044, 4'h8, 14'h0030}};
        apb(1'b0, 1'b1, `MD_CONFIG, 32'h0005_0304);
        apb(1'b0, 1'b1, `MD_TXTIME, 32'h0000_1000);
        apb(1'b1, 1'b1, `HE_HDR, 32'h0503_04AA);
        apb(1'b1, 1'b1, `HE_ALLOC, 32'hFFFF_FFFF);
        apb(1'b1, 1'b1, `HE_ACK, 32'h0000_0010);
        apb(1'b1, 1'b1, `HE_BO, 32'hFF01_FF02);
        apb(1'b1, 1'b1, `HE_IDX, 32'h0000_0000);
        for (int i = 0; i < 4; i++) apb(1'b1, 1'b1, `HE_ELEM, wr[i]);
        send_map();
        apb(1'b0, 1'b0, `MD_HDR, 32'h0000_0000);
        check(rdata, 32'h0503_0400);
        apb(1'b0, 1'b0, `MD_ALLOC, 32'h0000_0000);
        check(rdata, 32'h003F_FFFF);
        apb(1'b0, 1'b0, `MD_ACK, 32'h0000_0000);
        check(rdata, 32'h0000_0010);
        apb(1'b0, 1'b0, `MD_BO, 32'h0000_0000);
        check(rdata, 32'h0F01_0F02);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 1'b1, `MD_IDX, i);
            apb(1'b0, 1'b0, `MD_ELEM, 32'h0000_0000);
            check(rdata, ex[i]);
        end
        apb(1'b0, 1'b0, `MD_STATUS, 32'h0000_0000);
        check(rdata, 32'h0000_0001);
    endtask : t_map
    task automatic t_hdr(input logic [31:0] hdr, input logic [31:0] st);
        apb(1'b0, 1'b1, `MD_STATUS, 32'h0000_00FF);
        apb(1'b1, 1'b1, `HE_HDR, hdr);
        send_map();
        apb(1'b0, 1'b0, `MD_STATUS, 32'h0000_0000);
        check(rdata, st);
    endtask : t_hdr
    task automatic t_tlv();
        logic [16:0] tv [8];
        tv = '{17'h1_0101, 17'h1_0204, 17'h0_0203, 17'h1_0301, 17'h0_0300, 17'h1_0380,
            17'h0_0381, 17'h0_0400};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 1'b1, `MD_TLV, {16'h0000, tv[i][15:0]});
            apb(1'b0, 1'b0, `MD_TLV, 32'h0000_0000);
            check({31'h0, rdata[16]}, {31'h0, tv[i][16]});
        end
        apb(1'b0, 1'b0, 12'hFFC, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, 1'b0, 12'hFFC, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
    endtask : t_tlv
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        {presetn, h_psel, m_psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_map();
        t_decode();
        t_hdr(32'h0903_0000, 32'h0000_0002);
        t_hdr(32'h0507_0000, 32'h0000_0005);
        apb(1'b1, 1'b1, `HE_ACK, 32'h0000_2000);
        t_hdr(32'h0503_0000, 32'h0000_0081);
        t_tlv();
        complete_run();
    end
endmodule : tb
